// ---- rtl/mbae_exec.sv ----
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "mbae_cfg.svh"

module mbae_exec (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire mbae_pkg::mbae_wb_req_t wb_req,
  output mbae_pkg::mbae_wb_rsp_t wb_rsp,
  output logic [10:0] prog_addr,
  input wire logic [13:0] prog_data,
  output logic wdt_clear,
  output logic halted
);

  mbae_pkg::mbae_regs_t s_q;
  mbae_pkg::mbae_regs_t s_d;

  logic access;
  logic go;
  logic [31:0] rd_cur;
  logic [31:0] wv;
  mbae_pkg::mbae_op_t op;
  logic [5:0] ma;
  logic [2:0] bi;
  logic [7:0] mb;
  logic [7:0] opnd;
  logic cin;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] res;
  logic mem_wr;
  logic skip;
  logic tab;
  logic pcl_hit;
  logic [1:0] base;
  logic [1:0] icyc;
  logic [10:0] pc_next;
  logic [2:0] sp_push;
  logic [2:0] sp_pop;

  // ==========================================================
  // Bus read view
  always_comb
  begin
    rd_cur = 32'h0000_0000;
    unique case (wb_req.adr)
      `MBAE_REG_CMD:
      begin
        rd_cur[`MBAE_CMD_OP_LSB +: 5] = s_q.op;
        rd_cur[`MBAE_CMD_BIT_LSB +: 3] = s_q.bsel;
        rd_cur[`MBAE_CMD_MA_LSB +: 6] = s_q.maddr;
      end
      `MBAE_REG_OPND:
      begin
        rd_cur[`MBAE_OPND_IMM_LSB +: 8] = s_q.imm;
        rd_cur[`MBAE_OPND_TGT_LSB +: 11] = s_q.tgt;
      end
      `MBAE_REG_STAT:
      begin
        rd_cur[`MBAE_ST_BUSY] = (s_q.st == mbae_pkg::st_exec);
        rd_cur[`MBAE_ST_HALT] = (s_q.st == mbae_pkg::st_halted);
        rd_cur[`MBAE_ST_C] = s_q.c;
        rd_cur[`MBAE_ST_HC] = s_q.hc;
        rd_cur[`MBAE_ST_Z] = s_q.z;
        rd_cur[`MBAE_ST_OVF] = s_q.ovf;
        rd_cur[`MBAE_ST_PDF] = s_q.power_down_flag;
        rd_cur[`MBAE_ST_WTO] = s_q.wto;
        rd_cur[`MBAE_ST_SKIP] = s_q.skipped;
        rd_cur[`MBAE_ST_CLKS_LSB +: 4] = s_q.clocks;
      end
      `MBAE_REG_WREG: rd_cur[7:0] = s_q.wreg;
      `MBAE_REG_PC: rd_cur[10:0] = s_q.pc;
      `MBAE_REG_TABLE_READ_HIGH_BYTE: rd_cur[7:0] = s_q.table_read_high_byte;
      `MBAE_REG_MADDR: rd_cur[5:0] = s_q.swaddr;
      `MBAE_REG_MDATA: rd_cur[7:0] = s_q.mem[s_q.swaddr];
      default: rd_cur = 32'h0000_0000;
    endcase
    for (int i = 0; i < 4; i++)
    begin
      wv[i*8 +: 8] = wb_req.sel[i] ? wb_req.dat[i*8 +: 8] : rd_cur[i*8 +: 8];
    end
  end

  // ==========================================================
  // Operand fetch and arithmetic
  assign access = wb_req.cyc && wb_req.stb && !s_q.ack;
  assign go = access && wb_req.we && (wb_req.adr == `MBAE_REG_CMD)
    && (s_q.st == mbae_pkg::st_idle);
  assign op = mbae_pkg::mbae_op_t'(wv[`MBAE_CMD_OP_LSB +: 5]);
  assign ma = wv[`MBAE_CMD_MA_LSB +: 6];
  assign bi = wv[`MBAE_CMD_BIT_LSB +: 3];
  assign mb = s_q.mem[ma];
  assign opnd = (op == mbae_pkg::op_sum_imm_to_working
    || op == mbae_pkg::op_conjunction_imm_to_working) ? s_q.imm : mb;
  assign cin = (op == mbae_pkg::op_sum_with_carry_to_working
    || op == mbae_pkg::op_sum_with_carry_to_memory) ? s_q.c : 1'b0;
  assign sum9 = {1'b0, s_q.wreg} + {1'b0, opnd} + {8'h00, cin};
  // half carry out of bit 3
  assign sum5 = {1'b0, s_q.wreg[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
  assign sp_push = (s_q.sp == 3'(`MBAE_STACK_DEPTH - 1)) ? 3'h0 : s_q.sp + 3'h1;
  assign sp_pop = (s_q.sp == 3'h0) ? 3'(`MBAE_STACK_DEPTH - 1) : s_q.sp - 3'h1;

  // ==========================================================
  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.wdt_clear = 1'b0;
    res = 8'h00;
    mem_wr = 1'b0;
    skip = 1'b0;
    tab = 1'b0;
    base = 2'h1;
    pc_next = s_q.pc + 11'h001;
    if (access)
    begin
      s_d.ack = 1'b1;
      s_d.rdat = rd_cur;
      if (wb_req.we && s_q.st == mbae_pkg::st_idle)
      begin
        unique case (wb_req.adr)
          `MBAE_REG_OPND:
          begin
            s_d.imm = wv[`MBAE_OPND_IMM_LSB +: 8];
            s_d.tgt = wv[`MBAE_OPND_TGT_LSB +: 11];
          end
          `MBAE_REG_STAT:
          begin
            s_d.c = wv[`MBAE_ST_C];
            s_d.hc = wv[`MBAE_ST_HC];
            s_d.z = wv[`MBAE_ST_Z];
            s_d.ovf = wv[`MBAE_ST_OVF];
          end
          `MBAE_REG_WREG: s_d.wreg = wv[7:0];
          `MBAE_REG_PC: s_d.pc = wv[10:0];
          `MBAE_REG_MADDR: s_d.swaddr = wv[5:0];
          `MBAE_REG_MDATA: s_d.mem[s_q.swaddr] = wv[7:0];
          default: s_d.rdat = rd_cur;
        endcase
      end
      // Wake is the only write honoured in power-down
      if (wb_req.we && s_q.st == mbae_pkg::st_halted && wb_req.adr == `MBAE_REG_STAT
        && wv[`MBAE_ST_WAKE])
      begin
        s_d.st = mbae_pkg::st_idle;
      end
    end
    if (go)
    begin
      s_d.op = op;
      s_d.maddr = ma;
      s_d.bsel = bi;
      unique case (op)
        mbae_pkg::op_nop: res = 8'h00;
        mbae_pkg::op_direct_jump:
        begin
          base = 2'h2;
          pc_next = s_q.tgt;
        end
        mbae_pkg::op_skip_when_memory_zero: skip = (mb == 8'h00);
        mbae_pkg::op_copy_skip_zero:
        begin
          skip = (mb == 8'h00);
          s_d.wreg = mb;
        end
        mbae_pkg::op_skip_when_bit_zero: skip = !mb[bi];
        mbae_pkg::op_skip_when_bit_nonzero: skip = mb[bi];
        mbae_pkg::op_increment_skip_zero:
        begin
          res = mb + 8'h01;
          mem_wr = 1'b1;
          skip = (res == 8'h00);
        end
        mbae_pkg::op_decrement_skip_zero:
        begin
          res = mb - 8'h01;
          mem_wr = 1'b1;
          skip = (res == 8'h00);
        end
        mbae_pkg::op_increment_skip_zero_to_working:
        begin
          res = mb + 8'h01;
          s_d.wreg = res;
          skip = (res == 8'h00);
        end
        mbae_pkg::op_decrement_skip_zero_to_working:
        begin
          res = mb - 8'h01;
          s_d.wreg = res;
          skip = (res == 8'h00);
        end
        mbae_pkg::op_subroutine_invoke:
        begin
          base = 2'h2;
          s_d.stk[s_q.sp] = s_q.pc + 11'h001;
          s_d.sp = sp_push;
          pc_next = s_q.tgt;
        end
        mbae_pkg::op_subroutine_exit, mbae_pkg::op_interrupt_exit:
        begin
          base = 2'h2;
          s_d.sp = sp_pop;
          pc_next = s_q.stk[sp_pop];
        end
        mbae_pkg::op_return_with_value:
        begin
          base = 2'h2;
          s_d.sp = sp_pop;
          pc_next = s_q.stk[sp_pop];
          s_d.wreg = s_q.imm;
        end
        mbae_pkg::op_current_page_table_read, mbae_pkg::op_last_page_table_read:
        begin
          base = 2'h2;
          tab = 1'b1;
          s_d.prog_addr = {(op == mbae_pkg::op_last_page_table_read)
            ? `MBAE_LAST_PAGE : s_q.pc[10:8], s_q.imm};
        end
        mbae_pkg::op_memory_zero_fill:
        begin
          res = 8'h00;
          mem_wr = 1'b1;
        end
        mbae_pkg::op_memory_ones_fill:
        begin
          res = 8'hff;
          mem_wr = 1'b1;
        end
        mbae_pkg::op_watchdog_restart:
        begin
          s_d.wdt_clear = 1'b1;
          s_d.wto = 1'b0;
          s_d.power_down_flag = 1'b0;
          s_d.pre1 = 1'b0;
          s_d.pre2 = 1'b0;
        end
        mbae_pkg::op_watchdog_preclear_first, mbae_pkg::op_watchdog_preclear_second:
        begin
          if ((op == mbae_pkg::op_watchdog_preclear_first) ? s_q.pre2 : s_q.pre1)
          begin
            s_d.wdt_clear = 1'b1;
            s_d.wto = 1'b0;
            s_d.power_down_flag = 1'b0;
            s_d.pre1 = 1'b0;
            s_d.pre2 = 1'b0;
          end
          else if (op == mbae_pkg::op_watchdog_preclear_first)
          begin
            s_d.pre1 = 1'b1;
          end
          else
          begin
            s_d.pre2 = 1'b1;
          end
        end
        mbae_pkg::op_nibble_exchange:
        begin
          res = {mb[3:0], mb[7:4]};
          mem_wr = 1'b1;
        end
        mbae_pkg::op_nibble_exchange_to_working: s_d.wreg = {mb[3:0], mb[7:4]};
        mbae_pkg::op_power_down_entry:
        begin
          s_d.power_down_flag = 1'b1;
          s_d.wto = 1'b0;
          s_d.wdt_clear = 1'b1;
          s_d.halt_pend = 1'b1;
        end
        mbae_pkg::op_sum_with_carry_to_working, mbae_pkg::op_sum_with_carry_to_memory,
        mbae_pkg::op_sum_to_working, mbae_pkg::op_sum_imm_to_working,
        mbae_pkg::op_sum_to_memory:
        begin
          res = sum9[7:0];
          s_d.c = sum9[8];
          s_d.hc = sum5[4];
          s_d.z = (sum9[7:0] == 8'h00);
          s_d.ovf = (s_q.wreg[7] == opnd[7]) && (sum9[7] != s_q.wreg[7]);
          if (op == mbae_pkg::op_sum_with_carry_to_memory || op == mbae_pkg::op_sum_to_memory)
          begin
            mem_wr = 1'b1;
          end
          else
          begin
            s_d.wreg = res;
          end
        end
        mbae_pkg::op_conjunction_to_working, mbae_pkg::op_conjunction_imm_to_working,
        mbae_pkg::op_conjunction_to_memory:
        begin
          res = s_q.wreg & opnd;
          s_d.z = (res == 8'h00);
          if (op == mbae_pkg::op_conjunction_to_memory)
          begin
            mem_wr = 1'b1;
          end
          else
          begin
            s_d.wreg = res;
          end
        end
      endcase
      if (skip)
      begin
        pc_next = s_q.pc + 11'h002;
      end
      if (mem_wr)
      begin
        s_d.mem[ma] = res;
      end
      // low byte load reaches the counter
      if (mem_wr && ma == `MBAE_PCL_ADDR)
      begin
        pc_next = {s_q.pc[10:8], res};
      end
      s_d.pc = pc_next;
      s_d.skipped = skip;
      s_d.tab_pend = tab;
      s_d.clocks = 4'(icyc) * `MBAE_ICYC_CLOCKS;
      s_d.cnt = 4'(icyc) * `MBAE_ICYC_CLOCKS - 4'h1;
      s_d.st = mbae_pkg::st_exec;
    end
    if (s_q.st == mbae_pkg::st_exec)
    begin
      if (s_q.cnt == 4'h0)
      begin
        s_d.st = s_q.halt_pend ? mbae_pkg::st_halted : mbae_pkg::st_idle;
        s_d.halt_pend = 1'b0;
        if (s_q.tab_pend)
        begin
          // Word sampled on the last busy clock
          s_d.mem[s_q.maddr] = prog_data[7:0];
          s_d.table_read_high_byte = {2'b00, prog_data[13:8]};
          s_d.tab_pend = 1'b0;
          if (s_q.maddr == `MBAE_PCL_ADDR)
          begin
            s_d.pc = {s_q.pc[10:8], prog_data[7:0]};
          end
        end
      end
      else
      begin
        s_d.cnt = s_q.cnt - 4'h1;
      end
    end
  end

  // Cycle count decided up front, table write lands later
  assign pcl_hit = (mem_wr || tab) && (ma == `MBAE_PCL_ADDR);
  assign icyc = base + {1'b0, skip} + {1'b0, pcl_hit};

  // ==========================================================
  // State register
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      s_q <= '0;
      s_q.st <= mbae_pkg::st_idle;
      s_q.pc <= `MBAE_PC_RESET;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  assign wb_rsp = '{ack: s_q.ack, dat: s_q.rdat};
  assign prog_addr = s_q.prog_addr;
  assign wdt_clear = s_q.wdt_clear;
  assign halted = (s_q.st == mbae_pkg::st_halted);

  // ==========================================================
  // Checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_skip_extra_cycle: assert property (
    ce && go && op == mbae_pkg::op_skip_when_memory_zero && mb == 8'h00
      && ma != `MBAE_PCL_ADDR |=> s_q.clocks == 4'h8 && s_q.skipped)
    else $error("taken skip not stretched to eight clocks");
  chk_pcl_extra_cycle: assert property (
    ce && go && op == mbae_pkg::op_memory_ones_fill && ma == `MBAE_PCL_ADDR
      |=> s_q.clocks == 4'h8 && s_q.pc[7:0] == 8'hff)
    else $error("low byte load without extra cycle");
  chk_inc_in_place: assert property (
    ce && go && op == mbae_pkg::op_increment_skip_zero
      |=> s_q.mem[$past(ma)] == $past(mb) + 8'h01 && s_q.skipped == ($past(mb) == 8'hff))
    else $error("increment skip result wrong");
  chk_bit_test: assert property (
    ce && go && op == mbae_pkg::op_skip_when_bit_nonzero |=> s_q.skipped == $past(mb[bi]))
    else $error("bit test skip wrong");
  chk_call_push: assert property (
    ce && go && op == mbae_pkg::op_subroutine_invoke
      |=> s_q.pc == $past(s_q.tgt) && s_q.stk[$past(s_q.sp)] == $past(s_q.pc) + 11'h001)
    else $error("call did not push and load");
  chk_preclear_hold: assert property (
    ce && go && op == mbae_pkg::op_watchdog_preclear_first && !s_q.pre2
      |=> s_q.wto == $past(s_q.wto) && s_q.power_down_flag == $past(s_q.power_down_flag) && !wdt_clear)
    else $error("single preclear changed flags");
  chk_halt_flags: assert property (
    ce && go && op == mbae_pkg::op_power_down_entry
      |=> s_q.power_down_flag && !s_q.wto && wdt_clear && s_q.clocks == 4'h4)
    else $error("power-down entry flags wrong");
  chk_adc_sum: assert property (
    ce && go && op == mbae_pkg::op_sum_with_carry_to_working
      |=> s_q.wreg == $past(sum9[7:0]) && s_q.c == $past(sum9[8]) && s_q.hc == $past(sum5[4]))
    else $error("add with carry result wrong");
  chk_and_zero_only: assert property (
    ce && go && op == mbae_pkg::op_conjunction_to_working
      |=> s_q.c == $past(s_q.c) && s_q.ovf == $past(s_q.ovf) && s_q.z == (s_q.wreg == 8'h00))
    else $error("and touched other flags");

  cov_skip_taken: cover property (ce && go && skip);
  cov_table_read: cover property (ce && s_q.tab_pend && s_q.cnt == 4'h0);
  cov_halt_wake: cover property (halted ##1 !halted);

endmodule

// ---- include/mbae_cfg.svh ----
// Notes on behaviour
// - Taken skip adds one four-clock cycle
// - Writing program counter low byte adds cycle
// - Increment/decrement memory in place, skip on zero
// - Increment/decrement into working register, skip zero
// - Bit test skip on selected bit 0-7
// - Skip on zero byte, optional copy
// - Call pushes next address, loads target
// - Returns take two cycles, one loads immediate
// - Table read: low byte memory, high byte
// - Fill memory byte with zeros or ones
// - Preclears clear watchdog only after both preclears
// - Watchdog restart clears counter and both flags
// - Nibble swap in place or into working
// - Power-down entry one cycle, stops, updates flags
// - Power-down sets pd flag, clears expiry, watchdog
// - Jump loads target, two cycles, no flags
// - Add with carry into working, four flags
// - Add with carry into memory, four flags
// - Add memory into working or memory, immediate into working only
// - AND into working, only zero flag
// - AND into memory, only zero flag
`ifndef MBAE_CFG_SVH
`define MBAE_CFG_SVH

// ==========================================================
// Register map
`define MBAE_REG_CMD 8'h00
`define MBAE_REG_OPND 8'h04
`define MBAE_REG_STAT 8'h08
`define MBAE_REG_WREG 8'h0c
`define MBAE_REG_PC 8'h10
`define MBAE_REG_TABLE_READ_HIGH_BYTE 8'h14
`define MBAE_REG_MADDR 8'h18
`define MBAE_REG_MDATA 8'h1c

// ==========================================================
// Field positions
`define MBAE_CMD_OP_LSB 0
`define MBAE_CMD_BIT_LSB 8
`define MBAE_CMD_MA_LSB 16
`define MBAE_OPND_IMM_LSB 0
`define MBAE_OPND_TGT_LSB 16
`define MBAE_ST_BUSY 0
`define MBAE_ST_HALT 1
`define MBAE_ST_C 2
`define MBAE_ST_HC 3
`define MBAE_ST_Z 4
`define MBAE_ST_OVF 5
`define MBAE_ST_PDF 6
`define MBAE_ST_WTO 7
`define MBAE_ST_SKIP 8
`define MBAE_ST_CLKS_LSB 16
`define MBAE_ST_WAKE 0

// ==========================================================
// Sizes, addresses, timing
`define MBAE_DMEM_DEPTH 64
`define MBAE_STACK_DEPTH 6
`define MBAE_PCL_ADDR 6'h06
`define MBAE_LAST_PAGE 3'h7
`define MBAE_ICYC_CLOCKS 4'h4
`define MBAE_PC_RESET 11'h000

`endif

// ---- include/mbae_pkg.sv ----
`include "mbae_cfg.svh"

package mbae_pkg;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_exec = 3'b010,
    st_halted = 3'b100
  } mbae_state_t;

  typedef enum logic [4:0] {
    op_nop = 5'h00,
    op_direct_jump = 5'h01,
    op_skip_when_memory_zero = 5'h02,
    op_copy_skip_zero = 5'h03,
    op_skip_when_bit_zero = 5'h04,
    op_skip_when_bit_nonzero = 5'h05,
    op_increment_skip_zero = 5'h06,
    op_decrement_skip_zero = 5'h07,
    op_increment_skip_zero_to_working = 5'h08,
    op_decrement_skip_zero_to_working = 5'h09,
    op_subroutine_invoke = 5'h0a,
    op_subroutine_exit = 5'h0b,
    op_return_with_value = 5'h0c,
    op_interrupt_exit = 5'h0d,
    op_current_page_table_read = 5'h0e,
    op_last_page_table_read = 5'h0f,
    op_memory_zero_fill = 5'h10,
    op_memory_ones_fill = 5'h11,
    op_watchdog_restart = 5'h12,
    op_watchdog_preclear_first = 5'h13,
    op_watchdog_preclear_second = 5'h14,
    op_nibble_exchange = 5'h15,
    op_nibble_exchange_to_working = 5'h16,
    op_power_down_entry = 5'h17,
    op_sum_with_carry_to_working = 5'h18,
    op_sum_with_carry_to_memory = 5'h19,
    op_sum_to_working = 5'h1a,
    op_sum_imm_to_working = 5'h1b,
    op_sum_to_memory = 5'h1c,
    op_conjunction_to_working = 5'h1d,
    op_conjunction_imm_to_working = 5'h1e,
    op_conjunction_to_memory = 5'h1f
  } mbae_op_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } mbae_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } mbae_wb_rsp_t;

  typedef struct packed {
    mbae_state_t st;
    logic [`MBAE_DMEM_DEPTH-1:0][7:0] mem;
    logic [`MBAE_STACK_DEPTH-1:0][10:0] stk;
    logic [2:0] sp;
    logic [10:0] pc;
    logic [7:0] wreg;
    logic [7:0] table_read_high_byte;
    logic c;
    logic hc;
    logic z;
    logic ovf;
    logic power_down_flag;
    logic wto;
    logic pre1;
    logic pre2;
    mbae_op_t op;
    logic [2:0] bsel;
    logic [5:0] maddr;
    logic [7:0] imm;
    logic [10:0] tgt;
    logic [5:0] swaddr;
    logic [3:0] cnt;
    logic [3:0] clocks;
    logic skipped;
    logic tab_pend;
    logic halt_pend;
    logic [10:0] prog_addr;
    logic wdt_clear;
    logic ack;
    logic [31:0] rdat;
  } mbae_regs_t;

endpackage

// ---- testbench/mbae_prog_rom.sv ----
`timescale 1ns/100ps
// ==========================================================
// Program memory model
module mbae_prog_rom (
  input wire logic [10:0] prog_addr,
  output logic [13:0] prog_data
);
  // Every word differs, so a wrong page shows up in the high byte and a wrong pointer in the low byte
  assign prog_data = {prog_addr[10:5], prog_addr[7:0] ^ 8'h5a};
endmodule

// ---- testbench/mcu_branch_misc_arith_exec_bench.sv ----
`timescale 1ns/100ps
module mcu_branch_misc_arith_exec_bench;
  typedef struct packed {
    logic [4:0] op;
    logic [2:0] b;
    logic [7:0] m;
    logic [7:0] w;
    logic [7:0] imm;
    logic [3:0] fin;
    logic [7:0] em;
    logic [7:0] ew;
    logic [3:0] ef;
    logic sk;
  } mbae_row_t;

  logic mclk;
  logic nrst;
  logic ce;
  mbae_pkg::mbae_wb_req_t wb_req;
  mbae_pkg::mbae_wb_rsp_t wb_rsp;
  logic [10:0] prog_addr;
  logic [13:0] prog_data;
  logic wdt_clear;
  logic halted;
  int fail_count = 0;
  int total_checks = 0;
  int wdt_pulses = 0;
  logic [31:0] rd;
  logic [31:0] st;
  // Flags are {overflow, zero, half carry, carry}
  mbae_row_t rows [23] = '{
    '{5'h18, 3'h0, 8'h7f, 8'h01, 8'h00, 4'h1, 8'h7f, 8'h81, 4'ha, 1'h0},
    '{5'h19, 3'h0, 8'h80, 8'h80, 8'h00, 4'h0, 8'h00, 8'h80, 4'hd, 1'h0},
    '{5'h1a, 3'h0, 8'h0f, 8'h01, 8'h00, 4'h1, 8'h0f, 8'h10, 4'h2, 1'h0},
    '{5'h1b, 3'h0, 8'h55, 8'h01, 8'hff, 4'h0, 8'h55, 8'h00, 4'h7, 1'h0},
    '{5'h1c, 3'h0, 8'h40, 8'h40, 8'h00, 4'h0, 8'h80, 8'h40, 4'h8, 1'h0},
    '{5'h1d, 3'h0, 8'hf0, 8'h0f, 8'h00, 4'hb, 8'hf0, 8'h00, 4'hf, 1'h0},
    '{5'h1e, 3'h0, 8'h11, 8'hff, 8'h3c, 4'h4, 8'h11, 8'h3c, 4'h0, 1'h0},
    '{5'h1f, 3'h0, 8'haa, 8'h0f, 8'h00, 4'h5, 8'h0a, 8'h0f, 4'h1, 1'h0},
    '{5'h10, 3'h0, 8'h5a, 8'h33, 8'h00, 4'h9, 8'h00, 8'h33, 4'h9, 1'h0},
    '{5'h11, 3'h0, 8'h00, 8'h33, 8'h00, 4'h6, 8'hff, 8'h33, 4'h6, 1'h0},
    '{5'h15, 3'h0, 8'h3c, 8'h33, 8'h00, 4'h0, 8'hc3, 8'h33, 4'h0, 1'h0},
    '{5'h16, 3'h0, 8'h3c, 8'h33, 8'h00, 4'h0, 8'h3c, 8'hc3, 4'h0, 1'h0},
    '{5'h02, 3'h0, 8'h00, 8'h33, 8'h00, 4'h3, 8'h00, 8'h33, 4'h3, 1'h1},
    '{5'h02, 3'h0, 8'h01, 8'h33, 8'h00, 4'h0, 8'h01, 8'h33, 4'h0, 1'h0},
    '{5'h03, 3'h0, 8'h00, 8'h33, 8'h00, 4'h0, 8'h00, 8'h00, 4'h0, 1'h1},
    '{5'h03, 3'h0, 8'h5a, 8'h33, 8'h00, 4'h0, 8'h5a, 8'h5a, 4'h0, 1'h0},
    '{5'h04, 3'h7, 8'h7f, 8'h33, 8'h00, 4'h0, 8'h7f, 8'h33, 4'h0, 1'h1},
    '{5'h05, 3'h0, 8'h01, 8'h33, 8'h00, 4'h0, 8'h01, 8'h33, 4'h0, 1'h1},
    '{5'h05, 3'h7, 8'h7f, 8'h33, 8'h00, 4'h0, 8'h7f, 8'h33, 4'h0, 1'h0},
    '{5'h06, 3'h0, 8'hff, 8'h33, 8'h00, 4'ha, 8'h00, 8'h33, 4'ha, 1'h1},
    '{5'h07, 3'h0, 8'h02, 8'h33, 8'h00, 4'h5, 8'h01, 8'h33, 4'h5, 1'h0},
    '{5'h08, 3'h0, 8'hff, 8'h33, 8'h00, 4'h0, 8'hff, 8'h00, 4'h0, 1'h1},
    '{5'h09, 3'h0, 8'h01, 8'h33, 8'h00, 4'h0, 8'h01, 8'h00, 4'h0, 1'h1}};

  mbae_exec u_dut (.mclk(mclk), .nrst(nrst), .ce(ce), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .prog_addr(prog_addr), .prog_data(prog_data), .wdt_clear(wdt_clear), .halted(halted));
  mbae_prog_rom u_rom (.prog_addr(prog_addr), .prog_data(prog_data));

  initial
  begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    if (wdt_clear === 1'h1)
      wdt_pulses <= wdt_pulses + 1;
  end

  // ==========================================================
  // Bus and check tasks
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Ack and data are taken at the rising edge that sees ack, then released
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge mclk);
    wb_req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: adr, sel: 4'hf, dat: dat};
    do
    begin
      @(posedge mclk);
      n++;
    end while (wb_rsp.ack !== 1'h1 && n < 20);
    if (n >= 20)
      check("bus ack", 32'h1, 32'h0);
    rd = wb_rsp.dat;
    wb_req <= '0;
  endtask

  task automatic exec(input logic [4:0] op, input logic [2:0] b, input logic [5:0] a);
    int n;
    n = 0;
    bus(1'h1, 8'h00, {10'h0, a, 5'h0, b, 3'h0, op});
    do
    begin
      bus(1'h0, 8'h08, 32'h0);
      n++;
    end while (rd[0] !== 1'h0 && n < 20);
    st = rd;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #400000;
    fail_count++;
    test_done();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    mbae_row_t r;
    logic [10:0] pc0;
    logic [10:0] ta;
    logic [7:0] w0;
    int p0;
    nrst = 1'h0;
    ce = 1'h1;
    wb_req = '0;
    repeat (5) @(posedge mclk);
    nrst <= 1'h1;
    bus(1'h1, 8'h18, 32'h10);
    foreach (rows[i])
    begin
      r = rows[i];
      bus(1'h1, 8'h1c, {24'h0, r.m});
      bus(1'h1, 8'h0c, {24'h0, r.w});
      bus(1'h1, 8'h08, {26'h0, r.fin, 2'h0});
      bus(1'h1, 8'h04, {24'h0, r.imm});
      bus(1'h0, 8'h10, 32'h0);
      pc0 = rd[10:0];
      exec(r.op, r.b, 6'h10);
      check("flags", {28'h0, r.ef}, {28'h0, st[5:2]});
      check("skip", {31'h0, r.sk}, {31'h0, st[8]});
      check("clocks", {28'h0, r.sk ? 4'h8 : 4'h4}, {28'h0, st[19:16]});
      bus(1'h0, 8'h1c, 32'h0);
      check("memory", {24'h0, r.em}, rd);
      bus(1'h0, 8'h0c, 32'h0);
      check("working", {24'h0, r.ew}, rd);
      bus(1'h0, 8'h10, 32'h0);
      check("pc", {21'h0, pc0 + (r.sk ? 11'h2 : 11'h1)}, rd);
    end
    // Second reset in mid-run
    @(posedge mclk);
    nrst <= 1'h0;
    repeat (5) @(posedge mclk);
    nrst <= 1'h1;
    bus(1'h0, 8'h08, 32'h0);
    check("status after reset", 32'h0, rd);
    bus(1'h0, 8'h10, 32'h0);
    check("pc after reset", 32'h0, rd);
    bus(1'h0, 8'h40, 32'h0);
    check("unmapped read", 32'h0, rd);
    // Branches keep all four flags set
    bus(1'h1, 8'h08, 32'h3c);
    bus(1'h1, 8'h04, {5'h0, 11'h123, 16'h0});
    exec(5'h01, 3'h0, 6'h0);
    check("jump clocks", 32'h8, {28'h0, st[19:16]});
    check("jump flags", 32'hf, {28'h0, st[5:2]});
    bus(1'h1, 8'h04, {5'h0, 11'h200, 16'h0});
    exec(5'h0a, 3'h0, 6'h0);
    check("call clocks", 32'h8, {28'h0, st[19:16]});
    check("call flags", 32'hf, {28'h0, st[5:2]});
    bus(1'h0, 8'h10, 32'h0);
    check("call target", 32'h200, rd);
    bus(1'h1, 8'h04, 32'h77);
    exec(5'h0c, 3'h0, 6'h0);
    check("return clocks", 32'h8, {28'h0, st[19:16]});
    bus(1'h0, 8'h0c, 32'h0);
    check("return value", 32'h77, rd);
    // Each call pushes one past the previous return point
    for (int k = 0; k < 2; k++)
    begin
      bus(1'h1, 8'h04, {5'h0, 11'h300, 16'h0});
      exec(5'h0a, 3'h0, 6'h0);
      exec(k == 0 ? 5'h0b : 5'h0d, 3'h0, 6'h0);
      check("exit clocks", 32'h8, {28'h0, st[19:16]});
      bus(1'h0, 8'h10, 32'h0);
      check("return address", 32'h125 + k, rd);
    end
    // Table reads from the current and the last page
    bus(1'h1, 8'h18, 32'h10);
    bus(1'h1, 8'h04, 32'h34);
    for (int k = 0; k < 2; k++)
    begin
      bus(1'h0, 8'h10, 32'h0);
      ta = {k == 0 ? rd[10:8] : 3'h7, 8'h34};
      exec(k == 0 ? 5'h0e : 5'h0f, 3'h0, 6'h10);
      check("table clocks", 32'h8, {28'h0, st[19:16]});
      bus(1'h0, 8'h1c, 32'h0);
      check("table low", {24'h0, ta[7:0] ^ 8'h5a}, rd);
      bus(1'h0, 8'h14, 32'h0);
      check("table high", {26'h0, ta[10:5]}, rd);
    end
    // Writes to the program counter low byte
    exec(5'h10, 3'h0, 6'h06);
    check("pcl clocks", 32'h8, {28'h0, st[19:16]});
    bus(1'h1, 8'h18, 32'h06);
    bus(1'h1, 8'h1c, 32'hff);
    exec(5'h06, 3'h0, 6'h06);
    check("skip pcl clocks", 32'hc, {28'h0, st[19:16]});
    // Power down, wake, watchdog clears
    bus(1'h0, 8'h0c, 32'h0);
    w0 = rd[7:0];
    p0 = wdt_pulses;
    exec(5'h17, 3'h0, 6'h0);
    check("halt clocks", 32'h4, {28'h0, st[19:16]});
    check("halt flags", 32'h1, {30'h0, st[7:6]});
    check("halted", 32'h1, {31'h0, halted});
    check("halt clear", p0 + 1, wdt_pulses);
    bus(1'h1, 8'h0c, 32'h99);
    bus(1'h0, 8'h0c, 32'h0);
    check("held working", {24'h0, w0}, rd);
    bus(1'h1, 8'h08, 32'h1);
    exec(5'h13, 3'h0, 6'h0);
    exec(5'h13, 3'h0, 6'h0);
    check("one preclear", 32'h1, {31'h0, st[6]});
    check("one preclear pulse", p0 + 1, wdt_pulses);
    exec(5'h14, 3'h0, 6'h0);
    check("paired preclear", 32'h0, {30'h0, st[7:6]});
    check("paired pulse", p0 + 2, wdt_pulses);
    exec(5'h17, 3'h0, 6'h0);
    bus(1'h1, 8'h08, 32'h1);
    exec(5'h12, 3'h0, 6'h0);
    check("restart flags", 32'h0, {30'h0, st[7:6]});
    check("restart pulse", p0 + 4, wdt_pulses);
    test_done();
  end
endmodule
